// File: common/riod_pkg.sv
// constants, opcode enumerations and carriers of the integer opcode decoder
// How it works
// [RULE1] multiply step cc: minor 24, one cycle
// [RULE2] state/mask/trap-base reads: 29,2A,2B, one cycle
// [RULE3] auxiliary multiply read: minor 28, one cycle
// [RULE4] special reads use only op, rd, minor
// [RULE5] state and mask reads need supervisor
// [RULE6] upper immediate: op 0, op2 4, one cycle
// [RULE7] byte stores 05/15, three cycles, alt privileged
// [RULE8] half 06/16, word 04/14, alt privileged
// [RULE9] pair stores 07/17, four cycles
// [RULE10] fp register store: minor 24, three cycles
// [RULE11] fp status store: minor 25, four cycles
// [RULE12] fp queue 26, fp pair 27, four cycles
// [RULE13] subtract 04, subtract cc 14, one cycle
// [RULE14] subtract carry 00, with cc 1C, one cycle
// [RULE15] tagged add 20, trapping variant 22
// [RULE16] tagged subtract 21, trapping variant 23
// [RULE17] conditional trap: op 2, minor 3A, 1-4 cycles
// [RULE18] trap taken four cycles, else one
// [RULE19] branch taken one cycle, untaken two
// [RULE20] state register write: minor 31, supervisor only
// [RULE21] trap base write: minor 33, one cycle, supervisor
// [RULE22] fp operate 34 dispatched by opf code
// [RULE23] unmatched or unprivileged use blocked and trapped
package riod_pkg;

  // primary opcode field values
  localparam logic [1:0] OP_FMT2  = 2'h0;
  localparam logic [1:0] OP_CALL  = 2'h1;
  localparam logic [1:0] OP_ARITH = 2'h2;
  localparam logic [1:0] OP_MEM   = 2'h3;

  localparam logic [2:0] OP2_BRANCH_INT = 3'h2;
  localparam logic [2:0] OP2_SET_UPPER  = 3'h4;
  localparam logic [2:0] OP2_BRANCH_FP  = 3'h6;

  // minor opcodes under the arithmetic primary opcode
  localparam logic [5:0] MIN_MINUS_CARRY    = 6'h00;
  localparam logic [5:0] MIN_MINUS          = 6'h04;
  localparam logic [5:0] MIN_MINUS_CC       = 6'h14;
  localparam logic [5:0] MIN_MINUS_CARRY_CC = 6'h1C;
  localparam logic [5:0] MIN_TAG_SUM_CC     = 6'h20;
  localparam logic [5:0] MIN_TAG_DIFF_CC    = 6'h21;
  localparam logic [5:0] MIN_TAG_SUM_TV     = 6'h22;
  localparam logic [5:0] MIN_TAG_DIFF_TV    = 6'h23;
  localparam logic [5:0] MIN_MUL_STEP_CC    = 6'h24;
  localparam logic [5:0] MIN_READ_AUX_MUL   = 6'h28;
  localparam logic [5:0] MIN_READ_STATE     = 6'h29;
  localparam logic [5:0] MIN_READ_WIN_MASK  = 6'h2A;
  localparam logic [5:0] MIN_READ_TRAP_BASE = 6'h2B;
  localparam logic [5:0] MIN_WRITE_STATE    = 6'h31;
  localparam logic [5:0] MIN_WRITE_WIN_MASK = 6'h32;
  localparam logic [5:0] MIN_WRITE_TRAP_BASE = 6'h33;
  localparam logic [5:0] MIN_FP_OPERATE     = 6'h34;
  localparam logic [5:0] MIN_RETURN_TRAP    = 6'h39;
  localparam logic [5:0] MIN_COND_TRAP      = 6'h3A;
  localparam logic [5:0] MIN_SAVE_WIN       = 6'h3C;
  localparam logic [5:0] MIN_RESTORE_WIN    = 6'h3D;

  // minor opcodes under the memory primary opcode
  localparam logic [5:0] MIN_WORD_WR      = 6'h04;
  localparam logic [5:0] MIN_BYTE_WR      = 6'h05;
  localparam logic [5:0] MIN_HALF_WR      = 6'h06;
  localparam logic [5:0] MIN_PAIR_WR      = 6'h07;
  localparam logic [5:0] MIN_WORD_WR_ALT  = 6'h14;
  localparam logic [5:0] MIN_BYTE_WR_ALT  = 6'h15;
  localparam logic [5:0] MIN_HALF_WR_ALT  = 6'h16;
  localparam logic [5:0] MIN_PAIR_WR_ALT  = 6'h17;
  localparam logic [5:0] MIN_FP_REG_WR    = 6'h24;
  localparam logic [5:0] MIN_FP_STATUS_WR = 6'h25;
  localparam logic [5:0] MIN_FP_QUEUE_WR  = 6'h26;
  localparam logic [5:0] MIN_FP_PAIR_WR   = 6'h27;

  // floating-point operate codes
  localparam logic [8:0] OPF_MOVE_SINGLE = 9'h001;
  localparam logic [8:0] OPF_NEG_SINGLE  = 9'h005;
  localparam logic [8:0] OPF_DIFF_SINGLE = 9'h045;
  localparam logic [8:0] OPF_DIFF_DOUBLE = 9'h046;
  localparam logic [8:0] OPF_PROD_SINGLE = 9'h049;
  localparam logic [8:0] OPF_PROD_DOUBLE = 9'h04A;

  // cycle counts
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR  = 3'h4;
  localparam logic [2:0] CYC_RESET = 3'h0;

  typedef enum logic [5:0] {
    RIOD_NONE, RIOD_ILLEGAL, RIOD_CALL, RIOD_BRANCH_INT, RIOD_BRANCH_FP,
    RIOD_SET_UPPER_IMMEDIATE, RIOD_MULTIPLY_STEP_CC, RIOD_READ_AUX_MUL,
    RIOD_READ_STATE_REG, RIOD_READ_WINDOW_MASK, RIOD_READ_TRAP_BASE,
    RIOD_WRITE_STATE_REG, RIOD_WRITE_WINDOW_MASK, RIOD_WRITE_TRAP_BASE,
    RIOD_MINUS, RIOD_MINUS_CC, RIOD_MINUS_CARRY, RIOD_MINUS_CARRY_CC,
    RIOD_TAGGED_SUM_CC, RIOD_TAGGED_SUM_CC_OVERFLOW_TRAP,
    RIOD_TAGGED_DIFF_CC, RIOD_TAGGED_DIFF_CC_OVERFLOW_TRAP,
    RIOD_CONDITIONAL_TRAP, RIOD_FP_OPERATE, RIOD_SAVE, RIOD_RESTORE,
    RIOD_RETURN_FROM_TRAP,
    RIOD_BYTE_WRITER, RIOD_BYTE_WRITER_ALT, RIOD_HALF_WRITER,
    RIOD_HALF_WRITER_ALT, RIOD_WORD_WRITER, RIOD_WORD_WRITER_ALT,
    RIOD_PAIR_WRITER, RIOD_PAIR_WRITER_ALT, RIOD_FP_REG_WRITER,
    RIOD_FP_STATUS_WRITER, RIOD_FP_QUEUE_WRITER, RIOD_FP_PAIR_WRITER
  } riod_op_type;

  typedef enum logic [2:0] {
    RIOD_FP_NONE, RIOD_FP_MOVE_SINGLE, RIOD_FP_NEG_SINGLE,
    RIOD_FP_DIFFERENCE_SINGLE, RIOD_FP_DIFFERENCE_DOUBLE,
    RIOD_FP_PRODUCT_SINGLE, RIOD_FP_PRODUCT_DOUBLE, RIOD_FP_OTHER
  } riod_fpop_type;

  // format 3 view of an instruction word
  typedef struct packed {
    logic [1:0]  op;
    logic [4:0]  rd;
    logic [5:0]  minorOpcode;
    logic [4:0]  rs1;
    logic        useImm;
    logic [12:0] low;
  } riod_fmt3_type;

  typedef struct packed {
    logic          valid;
    riod_op_type   op;
    riod_fpop_type fpOp;
    logic [8:0]    opf;
    logic [2:0]    cycles;
    logic          privileged;
    logic          altSpace;
    logic          fpDispatch;
    logic          trapTaken;
    logic          illegalTrap;
    logic          privilegeTrap;
    logic          execute;
    logic [4:0]    rd;
    logic [4:0]    rs1;
    logic [4:0]    rs2;
    logic          useImm;
    logic [12:0]   imm13;
    logic [21:0]   imm22;
  } riod_decoded_type;

endpackage

// File: rtl/riod_decoder.sv
// single-cycle registered decoder for the second part of the integer instruction set
`timescale 1ns/100ps
`default_nettype none
module riod_decoder (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       instrValid,
  input  wire logic [31:0]                instr,
  input  wire logic                       supervisor,
  input  wire logic                       condTrue,
  output logic                            decValid,
  output riod_pkg::riod_decoded_type      decoded
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // cycle count for conditional flow; both branch and trap need it
  function automatic logic [2:0] condCycles(
    input logic       cond,
    input logic [2:0] whenTrue,
    input logic [2:0] whenFalse
  );
    condCycles = cond ? whenTrue : whenFalse;
  endfunction

  function automatic riod_pkg::riod_fpop_type fpLookup(input logic [8:0] code);
    riod_pkg::riod_fpop_type r;
    r = riod_pkg::RIOD_FP_OTHER;
    if (code == riod_pkg::OPF_MOVE_SINGLE) begin
      r = riod_pkg::RIOD_FP_MOVE_SINGLE;
    end else if (code == riod_pkg::OPF_NEG_SINGLE) begin
      r = riod_pkg::RIOD_FP_NEG_SINGLE;
    end else if (code == riod_pkg::OPF_DIFF_SINGLE) begin
      r = riod_pkg::RIOD_FP_DIFFERENCE_SINGLE;
    end else if (code == riod_pkg::OPF_DIFF_DOUBLE) begin
      r = riod_pkg::RIOD_FP_DIFFERENCE_DOUBLE; // [RULE22]
    end else if (code == riod_pkg::OPF_PROD_SINGLE) begin
      r = riod_pkg::RIOD_FP_PRODUCT_SINGLE; // [RULE22]
    end else if (code == riod_pkg::OPF_PROD_DOUBLE) begin
      r = riod_pkg::RIOD_FP_PRODUCT_DOUBLE; // [RULE22]
    end
    fpLookup = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational decode

  riod_pkg::riod_fmt3_type    f3;
  riod_pkg::riod_decoded_type decoded_d;
  riod_pkg::riod_decoded_type decoded_q;
  logic                       specialRead;
  logic                       altStore;

  assign f3 = riod_pkg::riod_fmt3_type'(instr);

  always_comb begin
    decoded_d               = '0;
    decoded_d.valid         = instrValid;
    decoded_d.op            = riod_pkg::RIOD_ILLEGAL;
    decoded_d.fpOp          = riod_pkg::RIOD_FP_NONE;
    decoded_d.cycles        = riod_pkg::CYC_ONE;
    decoded_d.rd            = f3.rd;
    decoded_d.rs1           = f3.rs1;
    decoded_d.rs2           = f3.low[4:0];
    decoded_d.useImm        = f3.useImm;
    decoded_d.imm13         = f3.low;
    specialRead             = 1'b0;
    altStore                = 1'b0;
    case (f3.op)
      riod_pkg::OP_FMT2: begin
        decoded_d.rs1    = 5'h00;
        decoded_d.rs2    = 5'h00;
        decoded_d.useImm = 1'b0;
        decoded_d.imm13  = 13'h0000;
        case (instr[24:22])
          riod_pkg::OP2_SET_UPPER: begin
            decoded_d.op     = riod_pkg::RIOD_SET_UPPER_IMMEDIATE; // [RULE6]
            decoded_d.imm22  = instr[21:0];
            decoded_d.cycles = riod_pkg::CYC_ONE; // [RULE6]
          end
          riod_pkg::OP2_BRANCH_INT: begin
            decoded_d.op     = riod_pkg::RIOD_BRANCH_INT;
            decoded_d.imm22  = instr[21:0];
            decoded_d.cycles = condCycles(condTrue, riod_pkg::CYC_ONE,
                                          riod_pkg::CYC_TWO); // [RULE19]
          end
          riod_pkg::OP2_BRANCH_FP: begin
            decoded_d.op     = riod_pkg::RIOD_BRANCH_FP;
            decoded_d.imm22  = instr[21:0];
            decoded_d.cycles = condCycles(condTrue, riod_pkg::CYC_ONE,
                                          riod_pkg::CYC_TWO); // [RULE19]
          end
          default: begin
            decoded_d.op = riod_pkg::RIOD_ILLEGAL; // [RULE23]
          end
        endcase
      end
      riod_pkg::OP_CALL: begin
        // only the low 22 bits of the displacement travel on, in imm22
        decoded_d.op     = riod_pkg::RIOD_CALL;
        decoded_d.rd     = 5'h00;
        decoded_d.rs1    = 5'h00;
        decoded_d.rs2    = 5'h00;
        decoded_d.useImm = 1'b0;
        decoded_d.imm13  = 13'h0000;
        decoded_d.imm22  = instr[21:0];
      end
      riod_pkg::OP_ARITH: begin
        case (f3.minorOpcode)
          riod_pkg::MIN_MUL_STEP_CC: begin
            decoded_d.op     = riod_pkg::RIOD_MULTIPLY_STEP_CC; // [RULE1]
            decoded_d.cycles = riod_pkg::CYC_ONE; // [RULE1]
          end
          riod_pkg::MIN_READ_AUX_MUL: begin
            decoded_d.op = riod_pkg::RIOD_READ_AUX_MUL; // [RULE3]
            specialRead  = 1'b1;
          end
          riod_pkg::MIN_READ_STATE: begin
            decoded_d.op         = riod_pkg::RIOD_READ_STATE_REG; // [RULE2]
            decoded_d.privileged = 1'b1; // [RULE5]
            specialRead          = 1'b1;
          end
          riod_pkg::MIN_READ_WIN_MASK: begin
            decoded_d.op         = riod_pkg::RIOD_READ_WINDOW_MASK; // [RULE2]
            decoded_d.privileged = 1'b1; // [RULE5]
            specialRead          = 1'b1;
          end
          riod_pkg::MIN_READ_TRAP_BASE: begin
            // unprivileged, like the auxiliary multiply read
            decoded_d.op = riod_pkg::RIOD_READ_TRAP_BASE; // [RULE2] [RULE5]
            specialRead  = 1'b1;
          end
          riod_pkg::MIN_MINUS: begin
            decoded_d.op = riod_pkg::RIOD_MINUS; // [RULE13]
          end
          riod_pkg::MIN_MINUS_CC: begin
            decoded_d.op = riod_pkg::RIOD_MINUS_CC; // [RULE13]
          end
          riod_pkg::MIN_MINUS_CARRY: begin
            decoded_d.op = riod_pkg::RIOD_MINUS_CARRY; // [RULE14]
          end
          riod_pkg::MIN_MINUS_CARRY_CC: begin
            decoded_d.op = riod_pkg::RIOD_MINUS_CARRY_CC; // [RULE14]
          end
          riod_pkg::MIN_TAG_SUM_CC: begin
            decoded_d.op = riod_pkg::RIOD_TAGGED_SUM_CC; // [RULE15]
          end
          riod_pkg::MIN_TAG_SUM_TV: begin
            decoded_d.op = riod_pkg::RIOD_TAGGED_SUM_CC_OVERFLOW_TRAP; // [RULE15]
          end
          riod_pkg::MIN_TAG_DIFF_CC: begin
            decoded_d.op = riod_pkg::RIOD_TAGGED_DIFF_CC; // [RULE16]
          end
          riod_pkg::MIN_TAG_DIFF_TV: begin
            decoded_d.op = riod_pkg::RIOD_TAGGED_DIFF_CC_OVERFLOW_TRAP; // [RULE16]
          end
          riod_pkg::MIN_COND_TRAP: begin
            decoded_d.op        = riod_pkg::RIOD_CONDITIONAL_TRAP; // [RULE17]
            decoded_d.trapTaken = condTrue;
            decoded_d.cycles    = condCycles(condTrue, riod_pkg::CYC_FOUR,
                                             riod_pkg::CYC_ONE); // [RULE18]
          end
          riod_pkg::MIN_WRITE_STATE: begin
            decoded_d.op         = riod_pkg::RIOD_WRITE_STATE_REG; // [RULE20]
            decoded_d.privileged = 1'b1; // [RULE20]
          end
          riod_pkg::MIN_WRITE_WIN_MASK: begin
            decoded_d.op         = riod_pkg::RIOD_WRITE_WINDOW_MASK;
            decoded_d.privileged = 1'b1;
          end
          riod_pkg::MIN_WRITE_TRAP_BASE: begin
            decoded_d.op         = riod_pkg::RIOD_WRITE_TRAP_BASE; // [RULE21]
            decoded_d.privileged = 1'b1; // [RULE21]
          end
          riod_pkg::MIN_FP_OPERATE: begin
            decoded_d.op         = riod_pkg::RIOD_FP_OPERATE; // [RULE22]
            decoded_d.opf        = instr[13:5];
            decoded_d.fpOp       = fpLookup(instr[13:5]); // [RULE22]
            decoded_d.fpDispatch = 1'b1; // [RULE22]
            decoded_d.useImm     = 1'b0;
            decoded_d.imm13      = 13'h0000;
          end
          riod_pkg::MIN_SAVE_WIN: begin
            decoded_d.op = riod_pkg::RIOD_SAVE;
          end
          riod_pkg::MIN_RESTORE_WIN: begin
            decoded_d.op = riod_pkg::RIOD_RESTORE;
          end
          riod_pkg::MIN_RETURN_TRAP: begin
            decoded_d.op         = riod_pkg::RIOD_RETURN_FROM_TRAP;
            decoded_d.privileged = 1'b1;
            decoded_d.cycles     = riod_pkg::CYC_TWO;
          end
          default: begin
            decoded_d.op = riod_pkg::RIOD_ILLEGAL; // [RULE23]
          end
        endcase
      end
      default: begin
        // memory group: every store listed here is at least three cycles
        decoded_d.cycles = riod_pkg::CYC_THREE;
        case (f3.minorOpcode)
          riod_pkg::MIN_BYTE_WR: begin
            decoded_d.op = riod_pkg::RIOD_BYTE_WRITER; // [RULE7]
          end
          riod_pkg::MIN_BYTE_WR_ALT: begin
            decoded_d.op = riod_pkg::RIOD_BYTE_WRITER_ALT; // [RULE7]
            altStore     = 1'b1;
          end
          riod_pkg::MIN_HALF_WR: begin
            decoded_d.op = riod_pkg::RIOD_HALF_WRITER; // [RULE8]
          end
          riod_pkg::MIN_HALF_WR_ALT: begin
            decoded_d.op = riod_pkg::RIOD_HALF_WRITER_ALT; // [RULE8]
            altStore     = 1'b1;
          end
          riod_pkg::MIN_WORD_WR: begin
            decoded_d.op = riod_pkg::RIOD_WORD_WRITER; // [RULE8]
          end
          riod_pkg::MIN_WORD_WR_ALT: begin
            decoded_d.op = riod_pkg::RIOD_WORD_WRITER_ALT; // [RULE8]
            altStore     = 1'b1;
          end
          riod_pkg::MIN_PAIR_WR: begin
            decoded_d.op     = riod_pkg::RIOD_PAIR_WRITER; // [RULE9]
            decoded_d.cycles = riod_pkg::CYC_FOUR; // [RULE9]
          end
          riod_pkg::MIN_PAIR_WR_ALT: begin
            decoded_d.op     = riod_pkg::RIOD_PAIR_WRITER_ALT; // [RULE9]
            decoded_d.cycles = riod_pkg::CYC_FOUR; // [RULE9]
            altStore         = 1'b1;
          end
          riod_pkg::MIN_FP_REG_WR: begin
            decoded_d.op = riod_pkg::RIOD_FP_REG_WRITER; // [RULE10]
          end
          riod_pkg::MIN_FP_STATUS_WR: begin
            decoded_d.op     = riod_pkg::RIOD_FP_STATUS_WRITER; // [RULE11]
            decoded_d.cycles = riod_pkg::CYC_FOUR; // [RULE11]
          end
          riod_pkg::MIN_FP_QUEUE_WR: begin
            decoded_d.op     = riod_pkg::RIOD_FP_QUEUE_WRITER; // [RULE12]
            decoded_d.cycles = riod_pkg::CYC_FOUR; // [RULE12]
          end
          riod_pkg::MIN_FP_PAIR_WR: begin
            decoded_d.op     = riod_pkg::RIOD_FP_PAIR_WRITER; // [RULE12]
            decoded_d.cycles = riod_pkg::CYC_FOUR; // [RULE12]
          end
          default: begin
            decoded_d.op     = riod_pkg::RIOD_ILLEGAL; // [RULE23]
            decoded_d.cycles = riod_pkg::CYC_ONE;
          end
        endcase
      end
    endcase

    // alternate-space stores carry the space in the asi field, so they are
    // privileged and an immediate form has no meaning
    if (altStore) begin
      decoded_d.privileged = 1'b1; // [RULE7] [RULE8] [RULE9]
      decoded_d.altSpace   = 1'b1;
      if (f3.useImm) begin
        decoded_d.op = riod_pkg::RIOD_ILLEGAL; // [RULE23]
      end
    end

    // special reads see only op, rd and minor opcode
    if (specialRead) begin
      decoded_d.rs1    = 5'h00; // [RULE4]
      decoded_d.rs2    = 5'h00; // [RULE4]
      decoded_d.useImm = 1'b0; // [RULE4]
      decoded_d.imm13  = 13'h0000; // [RULE4]
      decoded_d.cycles = riod_pkg::CYC_ONE; // [RULE2] [RULE3]
    end

    // an illegal encoding wins over a privilege fault
    if (decoded_d.op == riod_pkg::RIOD_ILLEGAL) begin
      decoded_d.illegalTrap = instrValid; // [RULE23]
      decoded_d.privileged  = 1'b0;
      decoded_d.fpDispatch  = 1'b0;
      decoded_d.trapTaken   = 1'b0;
      decoded_d.cycles      = riod_pkg::CYC_ONE;
    end else if (decoded_d.privileged && !supervisor) begin
      decoded_d.privilegeTrap = instrValid; // [RULE5] [RULE20] [RULE21] [RULE23]
      decoded_d.fpDispatch    = 1'b0;
      decoded_d.trapTaken     = 1'b0;
    end
    decoded_d.execute    = instrValid && !decoded_d.illegalTrap &&
                           !decoded_d.privilegeTrap; // [RULE23]
    decoded_d.fpDispatch = decoded_d.fpDispatch && instrValid;
    decoded_d.trapTaken  = decoded_d.trapTaken && instrValid;
    if (!instrValid) begin
      decoded_d.op = riod_pkg::RIOD_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output register: one cycle from instruction to decode

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      decoded_q <= '0;
    end else begin
      decoded_q <= decoded_d;
    end
  end

  assign decValid = decoded_q.valid;
  assign decoded  = decoded_q;

endmodule
`default_nettype wire

// File: tb/riod_decoder_props.sv
// port-level assertion checker for the integer opcode decoder
`timescale 1ns/100ps
`default_nettype none
module riod_decoder_props (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       instrValid,
  input wire logic [31:0]                instr,
  input wire logic                       supervisor,
  input wire logic                       condTrue,
  input wire logic                       decValid,
  input wire riod_pkg::riod_decoded_type decoded
);
  wire logic [1:0] pOp = instr[31:30];
  wire logic [5:0] mn  = instr[24:19];
  wire logic       ar  = instrValid && pOp == 2'h2;
  wire logic       mem = instrValid && pOp == 2'h3;
  wire logic       f2  = instrValid && pOp == 2'h0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  AST_MUL_STEP: assert property (ar && mn == 6'h24 |=> decoded.cycles == 3'h1 &&
    decoded.op == riod_pkg::RIOD_MULTIPLY_STEP_CC) else $error("multiply step decode wrong");
  AST_SUBTRACT: assert property (ar && mn inside {6'h00, 6'h04, 6'h14, 6'h1C, 6'h20,
    6'h21, 6'h22, 6'h23} |=> decoded.cycles == 3'h1 && decoded.execute)
    else $error("arithmetic op not one cycle");
  AST_READ_PRIV: assert property (ar && mn inside {6'h29, 6'h2A} && !supervisor
    |=> decoded.privilegeTrap && !decoded.execute) else $error("user read not trapped");
  // read fields: destination kept, rs1 cleared to zero and the immediate flag cleared
  AST_READ_FIELDS: assert property (ar && mn inside {[6'h28:6'h2B]} |=>
    decoded.rd == $past(instr[29:25]) && decoded.rs1 == 5'h00 && !decoded.useImm)
    else $error("read decode uses ignored fields");
  AST_STORE_THREE: assert property (mem && mn inside {6'h04, 6'h05, 6'h06, 6'h24}
    |=> decoded.cycles == 3'h3) else $error("store not three cycles");
  AST_STORE_FOUR: assert property (mem && mn inside {6'h07, 6'h25, 6'h26, 6'h27}
    |=> decoded.cycles == 3'h4) else $error("store not four cycles");
  AST_ALT_PRIV: assert property (mem && mn inside {[6'h14:6'h17]} && !instr[13] &&
    !supervisor |=> decoded.privilegeTrap && !decoded.execute) else $error("alt store in user");
  AST_COND_TRAP: assert property (ar && mn == 6'h3A |=> decoded.trapTaken == $past(condTrue)
    && decoded.cycles == ($past(condTrue) ? 3'h4 : 3'h1)) else $error("trap cycles wrong");
  AST_BRANCH: assert property (f2 && instr[24:22] == 3'h2 |=>
    decoded.cycles == ($past(condTrue) ? 3'h1 : 3'h2)) else $error("branch cycles wrong");
  AST_SET_UPPER: assert property (f2 && instr[24:22] == 3'h4 |=> decoded.cycles == 3'h1 &&
    decoded.imm22 == $past(instr[21:0])) else $error("upper immediate wrong");
  AST_FP_OPERATE: assert property (ar && mn == 6'h34 |=> decoded.fpDispatch &&
    decoded.opf == $past(instr[13:5])) else $error("fp operate not dispatched");
  AST_WRITE_PRIV: assert property (ar && mn inside {6'h31, 6'h33} && !supervisor
    |=> decoded.privilegeTrap && !decoded.execute) else $error("user write not trapped");
  AST_IDLE: assert property (!instrValid |=> !decValid && !decoded.execute)
    else $error("empty slot executed");

  COV_TRAP: cover property (decoded.trapTaken && decoded.cycles == 3'h4);
  COV_PRIV: cover property (decoded.privilegeTrap);
  COV_FP: cover property (decoded.fpDispatch);
endmodule

bind riod_decoder riod_decoder_props i_riod_decoder_props (.clk(clk), .rst_n(rst_n),
  .instrValid(instrValid), .instr(instr), .supervisor(supervisor), .condTrue(condTrue),
  .decValid(decValid), .decoded(decoded));
`default_nettype wire

// File: tb/test_risc_integer_opcode_decode.sv
// self-checking bench for the integer opcode decoder
`timescale 1ns/100ps
`default_nettype none
module test_risc_integer_opcode_decode;
  import riod_pkg::*;
  logic             clk;
  logic             rst_n;
  logic             instrValid;
  logic [31:0]      instr;
  logic             supervisor;
  logic             condTrue;
  logic             decValid;
  riod_decoded_type decoded;
  int               fails;
  int               tests_run;

  riod_decoder i_riod_decoder (.clk(clk), .rst_n(rst_n), .instrValid(instrValid),
    .instr(instr), .supervisor(supervisor), .condTrue(condTrue), .decValid(decValid),
    .decoded(decoded));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    tests_run++;
    if (seen !== expected) begin
      fails++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask

  task automatic give_verdict;
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // inputs move on the falling edge; result is read just after the next rising edge
  task automatic issue(input logic [31:0] w, input logic s, input logic c);
    @(negedge clk);
    instrValid = 1'b1;
    instr = w;
    supervisor = s;
    condTrue = c;
    @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] mk3(input logic [1:0] o, input logic [5:0] m);
    return {o, 5'h0A, m, 5'h03, 1'b0, 13'h0004};
  endfunction

  function automatic logic [31:0] seen();
    return {20'h0, decoded.op, decoded.cycles, decoded.execute, decoded.privilegeTrap,
      decoded.illegalTrap};
  endfunction

  function automatic logic [31:0] want(input riod_op_type o, input logic [2:0] c,
                                       input logic e, input logic p, input logic i);
    return {20'h0, o, c, e, p, i};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_arith;
    logic [5:0] m[12] = '{6'h24, 6'h04, 6'h14, 6'h00, 6'h1C, 6'h20, 6'h21, 6'h22, 6'h23,
                          6'h28, 6'h2B, 6'h33};
    riod_op_type e[12] = '{RIOD_MULTIPLY_STEP_CC, RIOD_MINUS, RIOD_MINUS_CC, RIOD_MINUS_CARRY,
      RIOD_MINUS_CARRY_CC, RIOD_TAGGED_SUM_CC, RIOD_TAGGED_DIFF_CC,
      RIOD_TAGGED_SUM_CC_OVERFLOW_TRAP, RIOD_TAGGED_DIFF_CC_OVERFLOW_TRAP, RIOD_READ_AUX_MUL,
      RIOD_READ_TRAP_BASE, RIOD_WRITE_TRAP_BASE};
    for (int k = 0; k < 12; k++) begin
      issue(mk3(2'h2, m[k]), k == 11, 1'b0);
      check(seen(), want(e[k], 3'h1, 1'b1, 1'b0, 1'b0));
    end
  endtask

  task automatic t_store;
    logic [5:0] m[12] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h14, 6'h15, 6'h16, 6'h17, 6'h24, 6'h25,
                          6'h26, 6'h27};
    logic [2:0] c[12] = '{3'h3, 3'h3, 3'h3, 3'h4, 3'h3, 3'h3, 3'h3, 3'h4, 3'h3, 3'h4, 3'h4, 3'h4};
    riod_op_type e[12] = '{RIOD_WORD_WRITER, RIOD_BYTE_WRITER, RIOD_HALF_WRITER,
      RIOD_PAIR_WRITER, RIOD_WORD_WRITER_ALT, RIOD_BYTE_WRITER_ALT, RIOD_HALF_WRITER_ALT,
      RIOD_PAIR_WRITER_ALT, RIOD_FP_REG_WRITER, RIOD_FP_STATUS_WRITER, RIOD_FP_QUEUE_WRITER,
      RIOD_FP_PAIR_WRITER};
    for (int k = 0; k < 12; k++) begin
      issue(mk3(2'h3, m[k]), 1'b1, 1'b0);
      check(seen(), want(e[k], c[k], 1'b1, 1'b0, 1'b0));
    end
  endtask

  // reads 29/2A, writes 31/33 and alternate stores in user mode must be held back
  task automatic t_priv;
    logic [7:0] m[8] = '{8'h29, 8'h2A, 8'h31, 8'h33, 8'hD4, 8'hD5, 8'hD6, 8'hD7};
    for (int k = 0; k < 8; k++) begin
      issue(mk3(m[k][7:6] | 2'h2, m[k][5:0]), 1'b0, 1'b0);
      check({decoded.execute, decoded.privilegeTrap}, 32'h1);
    end
  endtask

  // all ignorable bits set: the decode must not notice them
  task automatic t_read_ignore;
    riod_op_type e[2] = '{RIOD_READ_STATE_REG, RIOD_READ_WINDOW_MASK};
    for (int k = 0; k < 2; k++) begin
      issue({2'h2, 5'h11, 6'h29 + 6'(k), 19'h7FFFF}, 1'b1, 1'b1);
      check(seen(), want(e[k], 3'h1, 1'b1, 1'b0, 1'b0));
      check({decoded.rd, decoded.rs1, decoded.useImm}, 32'h440);
    end
  endtask

  task automatic t_set_upper_immediate;
    issue({2'h0, 5'h07, 3'h4, 22'h2ABCDE}, 1'b0, 1'b0);
    check(seen(), want(RIOD_SET_UPPER_IMMEDIATE, 3'h1, 1'b1, 1'b0, 1'b0));
    check(32'(decoded.imm22), 32'h2ABCDE);
  endtask

  task automatic t_trap_branch;
    for (int k = 0; k < 2; k++) begin
      issue(mk3(2'h2, 6'h3A), 1'b0, k[0]);
      check(seen(), want(RIOD_CONDITIONAL_TRAP, k ? 3'h4 : 3'h1, 1'b1, 1'b0, 1'b0));
      check(32'(decoded.trapTaken), 32'(k));
      issue({2'h0, 5'h08, 3'h2, 22'h000010}, 1'b0, k[0]);
      check(32'(decoded.cycles), k ? 32'h1 : 32'h2);
    end
  endtask

  task automatic t_fp;
    logic [8:0] f[3] = '{9'h04A, 9'h049, 9'h046};
    riod_fpop_type e[3] = '{RIOD_FP_PRODUCT_DOUBLE, RIOD_FP_PRODUCT_SINGLE,
                            RIOD_FP_DIFFERENCE_DOUBLE};
    for (int k = 0; k < 3; k++) begin
      issue({2'h2, 5'h02, 6'h34, 5'h01, f[k], 5'h03}, 1'b0, 1'b0);
      check({decoded.fpDispatch, decoded.fpOp, decoded.opf}, {1'b1, e[k], f[k]});
    end
  endtask

  // unknown codes, loads and an alternate store with an immediate; illegal beats privilege
  task automatic t_illegal;
    logic [31:0] w[3] = '{mk3(2'h2, 6'h3F), mk3(2'h3, 6'h00), mk3(2'h3, 6'h15) | 32'h2000};
    for (int k = 0; k < 3; k++) begin
      issue(w[k], 1'b0, 1'b0);
      check(seen(), want(RIOD_ILLEGAL, 3'h1, 1'b0, 1'b0, 1'b1));
    end
    @(negedge clk);
    instrValid = 1'b0;
    @(posedge clk);
    #1;
    check({decValid, decoded.op}, 32'h0);
  endtask

  // reset in mid-stream clears everything at once, decode resumes at the first edge
  task automatic t_reset;
    issue(mk3(2'h3, 6'h05), 1'b1, 1'b0);
    @(negedge clk);
    rst_n = 1'b0;
    #1;
    check(32'(decoded === '0), 32'h1);
    @(negedge clk);
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    check(seen(), want(RIOD_BYTE_WRITER, 3'h3, 1'b1, 1'b0, 1'b0));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    instrValid = 1'b0;
    instr = 32'h0;
    supervisor = 1'b0;
    condTrue = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_arith();
    t_store();
    t_priv();
    t_read_ignore();
    t_set_upper_immediate();
    t_trap_branch();
    t_fp();
    t_illegal();
    t_reset();
    give_verdict();
  end

  // about sixty cycles are needed; far more is a hang
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
